// ===== rtl/iapc_pkg.sv
/*
  Package for the in-application flash page controller: register map,
  field positions, keys, timing and the bus request carrier.
  Assumes a 50 MHz system clock and an APB master with 32-bit data.
*/
package iapc_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int WORD_W     = 16;
  localparam int ADDR_W     = 12;
  localparam int IDX_W      = 5;
  localparam int PAGE_W     = 7;
  localparam int PAGE_WORDS = 32;
  localparam int MEM_WORDS  = 4096;
  localparam logic [IDX_W-1:0]  LAST_IDX   = 5'h1f;
  localparam logic [WORD_W-1:0] ERASED_VAL = 16'hffff;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL    = 8'h00;
  localparam logic [APB_AW-1:0] OFS_BUF_CLR = 8'h04;
  localparam logic [APB_AW-1:0] OFS_ADDR_LO = 8'h08;
  localparam logic [APB_AW-1:0] OFS_ADDR_HI = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_DATA_LO = 8'h10;
  localparam logic [APB_AW-1:0] OFS_DATA_HI = 8'h14;
  localparam logic [APB_AW-1:0] OFS_RD_DATA = 8'h18;
  localparam logic [APB_AW-1:0] OFS_INT_ST  = 8'h1c;
  localparam logic [APB_AW-1:0] OFS_INT_CLR = 8'h20;
  localparam logic [APB_AW-1:0] OFS_INT_EN  = 8'h24;
  localparam logic [APB_AW-1:0] OFS_UNLOCK  = 8'h28;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int CTRL_RD_START = 0;
  localparam int CTRL_RD_EN    = 1;
  localparam int CTRL_WR_START = 2;
  localparam int CTRL_ER_START = 3;
  localparam int CTRL_EW_FLAG  = 7;
  localparam int BUF_CLR_BIT   = 0;
  localparam int BYTE_W        = 8;
  localparam int HI_ADDR_W     = 4;

  localparam logic [31:0] KEY_FIRST  = 32'h0000_00a5;
  localparam logic [31:0] KEY_SECOND = 32'h0000_005a;

  // ****************************************************************
  // interrupt events
  // ****************************************************************
  localparam int EV_W       = 4;
  localparam int EV_WR_DONE = 0;
  localparam int EV_RD_DONE = 1;
  localparam int EV_ER_DONE = 2;
  localparam int EV_CLR_DNE = 3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS        = 20;
  localparam int ERASE_TIME_NS = 2000;
  localparam int PROG_TIME_NS  = 1000;
  localparam int READ_TIME_NS  = 60;
  localparam int CNT_W         = 8;
  localparam logic [CNT_W-1:0] ERASE_CYC =
    CNT_W'((ERASE_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PROG_CYC =
    CNT_W'((PROG_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] READ_CYC =
    CNT_W'((READ_TIME_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } iapc_apb_req_t;

  typedef struct packed {
    logic erase_done;
    logic prog_done;
    logic read_done;
  } iapc_done_t;

  typedef enum logic [2:0] {
    FC_IDLE, FC_ERASE, FC_PROG_LOAD, FC_PROG_WAIT, FC_READ
  } iapc_fc_state_t;

endpackage

// ===== rtl/iapc_wbuf.sv
/*
  Page-sized write buffer with per-word valid bits and a clear sequencer.
  Assumes the caller does not write while a clear is running.
*/
`timescale 1ns/10ps
module iapc_wbuf (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          clr_start,
  output logic                               clr_busy,
  input  wire logic                          we,
  input  wire logic [iapc_pkg::IDX_W-1:0]    widx,
  input  wire logic [iapc_pkg::WORD_W-1:0]   wdata,
  input  wire logic [iapc_pkg::IDX_W-1:0]    ridx,
  output logic [iapc_pkg::WORD_W-1:0]        rdata,
  output logic                               rvalid
);
  import iapc_pkg::*;

  // ****************************************************************
  // storage: exactly one page
  // ****************************************************************
  logic [WORD_W-1:0] data_q  [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] valid_q;
  logic              busy_q;
  logic [IDX_W-1:0]  cidx_q;

  assign clr_busy = busy_q;
  assign rdata    = data_q[ridx];
  assign rvalid   = valid_q[ridx];

  // one word per cycle keeps the clear cheap; costs 32 cycles of busy
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      cidx_q <= '0;
    end else if (clr_start && !busy_q) begin
      busy_q <= 1'b1;
      cidx_q <= '0;
    end else if (busy_q) begin
      cidx_q <= cidx_q + 5'h01;
      if (cidx_q == LAST_IDX) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      valid_q <= '0;
    end else if (busy_q) begin
      valid_q[cidx_q] <= 1'b0;
    end else if (we) begin
      valid_q[widx] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (busy_q) begin
      data_q[cidx_q] <= ERASED_VAL;
    end else if (we) begin
      data_q[widx] <= wdata;
    end
  end

endmodule

// ===== rtl/iapc_core.sv
/*
  Flash array with page erase, page program from the write buffer and
  single-word read. Assumes go pulses arrive only while idle.
*/
`timescale 1ns/10ps
module iapc_core (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          erase_go,
  input  wire logic                          prog_go,
  input  wire logic                          read_go,
  input  wire logic [iapc_pkg::ADDR_W-1:0]   addr,
  output logic [iapc_pkg::IDX_W-1:0]         buf_idx,
  input  wire logic [iapc_pkg::WORD_W-1:0]   buf_data,
  input  wire logic                          buf_valid,
  output iapc_pkg::iapc_done_t               done,
  output logic [iapc_pkg::WORD_W-1:0]        read_word
);
  import iapc_pkg::*;

  logic [WORD_W-1:0]  mem_q [MEM_WORDS];
  iapc_fc_state_t     st_q;
  logic [PAGE_W-1:0]  page_q;
  logic [IDX_W-1:0]   idx_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [WORD_W-1:0]  rword_q;
  iapc_done_t         done_q;

  assign buf_idx   = idx_q;
  assign done      = done_q;
  assign read_word = rword_q;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q   <= FC_IDLE;
      page_q <= '0;
      idx_q  <= '0;
      cnt_q  <= '0;
      done_q <= '0;
    end else begin
      done_q <= '0;
      unique case (st_q)
        FC_IDLE: begin
          page_q <= addr[ADDR_W-1:IDX_W];
          idx_q  <= addr[IDX_W-1:0];
          if (erase_go) begin
            st_q  <= FC_ERASE;
            cnt_q <= ERASE_CYC;
          end else if (prog_go) begin
            st_q  <= FC_PROG_LOAD;
            idx_q <= '0;
          end else if (read_go) begin
            st_q  <= FC_READ;
            cnt_q <= READ_CYC;
          end
        end
        FC_ERASE: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q              <= FC_IDLE;
            done_q.erase_done <= 1'b1;
          end
        end
        FC_PROG_LOAD: begin
          idx_q <= idx_q + 5'h01;
          if (idx_q == LAST_IDX) begin
            st_q  <= FC_PROG_WAIT;
            cnt_q <= PROG_CYC;
          end
        end
        FC_PROG_WAIT: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q             <= FC_IDLE;
            done_q.prog_done <= 1'b1;
          end
        end
        FC_READ: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q             <= FC_IDLE;
            done_q.read_done <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // array: programming only clears bits, so unerased words merge
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (st_q == FC_IDLE && erase_go) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        mem_q[{addr[ADDR_W-1:IDX_W], IDX_W'(i)}] <= ERASED_VAL;
      end
    end else if (st_q == FC_PROG_LOAD && buf_valid) begin
      mem_q[{page_q, idx_q}] <= mem_q[{page_q, idx_q}] & buf_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rword_q <= '0;
    end else if (st_q == FC_READ && cnt_q == 8'h01) begin
      rword_q <= mem_q[{page_q, idx_q}];
    end
  end

endmodule

// ===== rtl/iapc_top.sv
/*
  In-application flash page controller: APB register slave, unlock
  sequence, address and data staging, start/busy bits and interrupts.
  Assumes one 50 MHz clock, synchronous reset and an APB master.
*/
`timescale 1ns/10ps
module iapc_top (
  input  wire logic                  CLOCK,
  input  wire logic                  SRST,
  input  wire iapc_pkg::iapc_apb_req_t APB_REQ,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  output logic                       IRQ
);
  import iapc_pkg::*;

  // ****************************************************************
  // apb slave: one wait state, answer always from flops
  // ****************************************************************
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;
  logic              acc;
  logic              wr_acc;
  logic              mapped;
  logic [31:0]       rd_mux;

  function automatic logic hit(input logic [APB_AW-1:0] ofs);
    hit = wr_acc && (APB_REQ.paddr == ofs);
  endfunction

  assign acc    = APB_REQ.psel && APB_REQ.penable && !pready_q;
  assign wr_acc = acc && APB_REQ.pwrite;

  // ****************************************************************
  // control state
  // ****************************************************************
  logic                ew_flag_q;
  logic                key_armed_q;
  logic                rd_en_q;
  logic                wr_busy_q;
  logic                rd_busy_q;
  logic                er_busy_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [BYTE_W-1:0]   data_lo_q;
  logic [BYTE_W-1:0]   data_hi_q;
  logic [WORD_W-1:0]   rd_data_q;
  logic [EV_W-1:0]     status_q;
  logic [EV_W-1:0]     enable_q;
  logic                irq_q;
  logic                any_busy;
  logic                clr_busy;
  logic                clr_busy_d1_q;
  logic                buf_we;
  logic                clr_start;
  logic                erase_go;
  logic                prog_go;
  logic                read_go;
  logic [WORD_W-1:0]   buf_word;
  logic [IDX_W-1:0]    core_idx;
  logic [WORD_W-1:0]   core_bdata;
  logic                core_bvalid;
  logic [WORD_W-1:0]   core_word;
  iapc_done_t          done;
  logic [EV_W-1:0]     events;

  assign any_busy = wr_busy_q || rd_busy_q || er_busy_q || clr_busy;
  assign erase_go = hit(OFS_CTRL) && APB_REQ.pwdata[CTRL_ER_START] &&
                    ew_flag_q && !any_busy;
  assign prog_go  = hit(OFS_CTRL) && APB_REQ.pwdata[CTRL_WR_START] &&
                    ew_flag_q && !any_busy && !erase_go;
  assign read_go  = hit(OFS_CTRL) && APB_REQ.pwdata[CTRL_RD_START] &&
                    rd_en_q && !any_busy && !erase_go &&
                    !prog_go;
  // a stale buffer or an in-flight page write must not be overwritten
  assign buf_we   = hit(OFS_DATA_HI) && ew_flag_q && !clr_busy &&
                    !wr_busy_q;
  assign buf_word = {APB_REQ.pwdata[BYTE_W-1:0], data_lo_q};
  assign clr_start = done.prog_done ||
                     (hit(OFS_BUF_CLR) && APB_REQ.pwdata[BUF_CLR_BIT]);
  assign events   = {clr_busy_d1_q && !clr_busy, done.erase_done,
                     done.read_done, done.prog_done};

  // ****************************************************************
  // unlock sequence and enable bits
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ew_flag_q   <= 1'b0;
      key_armed_q <= 1'b0;
    end else if (hit(OFS_UNLOCK)) begin
      key_armed_q <= !key_armed_q && (APB_REQ.pwdata == KEY_FIRST);
      if (key_armed_q && APB_REQ.pwdata == KEY_SECOND) begin
        ew_flag_q <= 1'b1;
      end
    end else if (hit(OFS_CTRL) && !APB_REQ.pwdata[CTRL_EW_FLAG]) begin
      ew_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rd_en_q <= 1'b0;
    end else if (hit(OFS_CTRL)) begin
      rd_en_q <= APB_REQ.pwdata[CTRL_RD_EN];
    end
  end

  // ****************************************************************
  // start / busy bits: set by software, cleared by completion
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wr_busy_q <= 1'b0;
      rd_busy_q <= 1'b0;
      er_busy_q <= 1'b0;
    end else begin
      if (prog_go) begin
        wr_busy_q <= 1'b1;
      end else if (done.prog_done) begin
        wr_busy_q <= 1'b0;
      end
      if (read_go) begin
        rd_busy_q <= 1'b1;
      end else if (done.read_done) begin
        rd_busy_q <= 1'b0;
      end
      if (erase_go) begin
        er_busy_q <= 1'b1;
      end else if (done.erase_done) begin
        er_busy_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // address and data staging
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      addr_q <= '0;
    end else if (buf_we) begin
      if (addr_q[IDX_W-1:0] != LAST_IDX) begin
        addr_q <= addr_q + 12'h001;
      end
    end else if (hit(OFS_ADDR_LO)) begin
      addr_q[BYTE_W-1:0] <= APB_REQ.pwdata[BYTE_W-1:0];
    end else if (hit(OFS_ADDR_HI)) begin
      addr_q[ADDR_W-1:BYTE_W] <= APB_REQ.pwdata[HI_ADDR_W-1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      data_lo_q <= '0;
      data_hi_q <= '0;
    end else begin
      if (hit(OFS_DATA_LO)) begin
        data_lo_q <= APB_REQ.pwdata[BYTE_W-1:0];
      end
      if (hit(OFS_DATA_HI)) begin
        data_hi_q <= APB_REQ.pwdata[BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rd_data_q <= '0;
    end else if (done.read_done) begin
      rd_data_q <= core_word;
    end
  end

  // ****************************************************************
  // interrupts: a new event wins over a clear in the same cycle
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      status_q      <= '0;
      enable_q      <= '0;
      irq_q         <= 1'b0;
      clr_busy_d1_q <= 1'b0;
    end else begin
      clr_busy_d1_q <= clr_busy;
      if (hit(OFS_INT_CLR)) begin
        status_q <= (status_q & ~APB_REQ.pwdata[EV_W-1:0]) | events;
      end else begin
        status_q <= status_q | events;
      end
      if (hit(OFS_INT_EN)) begin
        enable_q <= APB_REQ.pwdata[EV_W-1:0];
      end
      irq_q <= |(status_q & enable_q);
    end
  end

  // ****************************************************************
  // read mux and bus answer
  // ****************************************************************
  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    unique case (APB_REQ.paddr)
      OFS_CTRL: begin
        rd_mux[CTRL_EW_FLAG]  = ew_flag_q;
        rd_mux[CTRL_ER_START] = er_busy_q;
        rd_mux[CTRL_WR_START] = wr_busy_q;
        rd_mux[CTRL_RD_EN]    = rd_en_q;
        rd_mux[CTRL_RD_START] = rd_busy_q;
      end
      OFS_BUF_CLR: rd_mux[BUF_CLR_BIT]       = clr_busy;
      OFS_ADDR_LO: rd_mux[BYTE_W-1:0]        = addr_q[BYTE_W-1:0];
      OFS_ADDR_HI: rd_mux[HI_ADDR_W-1:0]     = addr_q[ADDR_W-1:BYTE_W];
      OFS_DATA_LO: rd_mux[BYTE_W-1:0]        = data_lo_q;
      OFS_DATA_HI: rd_mux[BYTE_W-1:0]        = data_hi_q;
      OFS_RD_DATA: rd_mux[WORD_W-1:0]        = rd_data_q;
      OFS_INT_ST:  rd_mux[EV_W-1:0]          = status_q;
      OFS_INT_EN:  rd_mux[EV_W-1:0]          = enable_q;
      OFS_INT_CLR, OFS_UNLOCK: rd_mux        = '0;
      default:     mapped                    = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      if (acc && !APB_REQ.pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA  = prdata_q;
  assign IRQ     = irq_q;

  // ****************************************************************
  // submodules
  // ****************************************************************
  iapc_wbuf u_wbuf (
    .clk      (CLOCK),
    .srst     (SRST),
    .clr_start(clr_start),
    .clr_busy (clr_busy),
    .we       (buf_we),
    .widx     (addr_q[IDX_W-1:0]),
    .wdata    (buf_word),
    .ridx     (core_idx),
    .rdata    (core_bdata),
    .rvalid   (core_bvalid)
  );

  iapc_core u_core (
    .clk      (CLOCK),
    .srst     (SRST),
    .erase_go (erase_go),
    .prog_go  (prog_go),
    .read_go  (read_go),
    .addr     (addr_q),
    .buf_idx  (core_idx),
    .buf_data (core_bdata),
    .buf_valid(core_bvalid),
    .done     (done),
    .read_word(core_word)
  );

  // ****************************************************************
  // assertions
  // ****************************************************************
  // a locked data-high write must neither load nor step the address
  property p_buf_needs_flag;
    @(posedge CLOCK) disable iff (SRST)
      hit(OFS_DATA_HI) && !ew_flag_q |=> $stable(addr_q);
  endproperty
  a_buf_needs_flag: assert property (p_buf_needs_flag)
    else $error("buffer written without erase/write flag");

  property p_addr_step;
    @(posedge CLOCK) disable iff (SRST)
      buf_we && addr_q[IDX_W-1:0] != LAST_IDX |=>
        addr_q == $past(addr_q) + 12'h001;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address did not step after data load");

  property p_addr_hold;
    @(posedge CLOCK) disable iff (SRST)
      buf_we && addr_q[IDX_W-1:0] == LAST_IDX |=> $stable(addr_q);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address left the last word of the page");

  property p_flag_after_key;
    @(posedge CLOCK) disable iff (SRST)
      hit(OFS_UNLOCK) && key_armed_q && APB_REQ.pwdata == KEY_SECOND
        |=> ew_flag_q;
  endproperty
  a_flag_after_key: assert property (p_flag_after_key)
    else $error("flag not raised after unlock");

  property p_wr_busy_ends;
    @(posedge CLOCK) disable iff (SRST)
      prog_go |=> wr_busy_q ##[30:120] !wr_busy_q;
  endproperty
  a_wr_busy_ends: assert property (p_wr_busy_ends)
    else $error("write busy not cleared in time");

  property p_read_needs_en;
    @(posedge CLOCK) disable iff (SRST) $rose(rd_busy_q) |-> $past(rd_en_q);
  endproperty
  a_read_needs_en: assert property (p_read_needs_en)
    else $error("read started with read disabled");

  property p_rd_busy_ends;
    @(posedge CLOCK) disable iff (SRST)
      $rose(rd_busy_q) |-> rd_busy_q[*3] ##[1:4] !rd_busy_q;
  endproperty
  a_rd_busy_ends: assert property (p_rd_busy_ends)
    else $error("read busy wrong length");

  property p_auto_clear;
    @(posedge CLOCK) disable iff (SRST)
      done.prog_done |=> clr_busy ##[31:33] !clr_busy;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("buffer not cleared after page write");

  property p_clear_bit_drops;
    @(posedge CLOCK) disable iff (SRST)
      $rose(clr_busy) |-> clr_busy[*8] ##[20:30] !clr_busy;
  endproperty
  a_clear_bit_drops: assert property (p_clear_bit_drops)
    else $error("buffer clear bit did not drop in time");

endmodule

// ===== tb/iapc_test.sv
/*
  Bench for iapc_top: APB master tasks, a small page model and checks.
  Assumes iapc_pkg and the rtl files are compiled first.
*/
`timescale 1ns/10ps
module iap_flash_page_controller_test;
  import iapc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic          CLOCK;
  logic          SRST;
  logic          PREADY;
  logic          PSLVERR;
  logic          IRQ;
  logic          err;
  logic [31:0]   PRDATA;
  logic [31:0]   rd;
  iapc_apb_req_t req;
  int            n_fail;
  int            total_checks;
  int            cyc = 0;
  int            p;
  int            i;
  int            mdl[32];

  iapc_top dut_u (.CLOCK(CLOCK), .SRST(SRST), .APB_REQ(req),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_sim;
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // request held until pready is sampled high, then released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge CLOCK);
    req.penable <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // software side: poll a busy bit low, bounded
  task poll(input int b, input logic [7:0] a);
    int n;
    n = 0;
    do begin
      rr(a);
      n++;
    end while (rd[b] !== 1'b0 && n < 300);
  endtask

  // hang guard, about fourteen times the expected run
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim;
    end
  end

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    req = '0;
    SRST = 1'b1;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(79));
    repeat (10) @(posedge CLOCK);
    SRST <= 1'b0;
    p = $urandom % 128;
    rr(OFS_CTRL);
    chk("flag", rd[7], 1'b0);
    rr(8'h2c);
    chk("unmapped err", err, 1'b1);
    chk("unmapped rd", rd, 32'h0);
    wr(OFS_ADDR_HI, p >> 3);
    wr(OFS_ADDR_LO, {p[2:0], 5'h00});
    wr(OFS_DATA_HI, 32'h12);
    rr(OFS_ADDR_LO);
    chk("locked", rd, {p[2:0], 5'h00});
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
    rr(OFS_CTRL);
    chk("flag", rd[7], 1'b1);
    wr(OFS_INT_EN, 32'hf);
    wr(OFS_CTRL, 32'h88);
    poll(CTRL_ER_START, OFS_CTRL);
    wr(OFS_BUF_CLR, 32'h1);
    poll(0, OFS_BUF_CLR);
    rr(OFS_INT_ST);
    chk("events", rd[3:2], 2'b11);
    for (i = 0; i < 32; i++) begin
      mdl[i] = $urandom & 32'hffff;
      wr(OFS_DATA_LO, mdl[i] & 32'hff);
      wr(OFS_DATA_HI, mdl[i] >> 8);
      rr(OFS_ADDR_LO);
      chk("step", rd, {p[2:0], 5'(i < 31 ? i + 1 : 31)});
    end
    wr(OFS_INT_CLR, 32'hf);
    wr(OFS_CTRL, 32'h84);
    rr(OFS_CTRL);
    chk("wstart", rd[2], 1'b1);
    poll(CTRL_WR_START, OFS_CTRL);
    chk("wbusy", rd[2], 1'b0);
    poll(0, OFS_BUF_CLR);
    chk("autoclr", rd[0], 1'b0);
    rr(OFS_INT_ST);
    chk("wr events", rd[3:0], 4'b1001);
    chk("irq", IRQ, 1'b1);
    wr(OFS_INT_EN, 32'h0);
    repeat (2) @(posedge CLOCK);
    chk("mask", IRQ, 1'b0);
    wr(OFS_INT_CLR, 32'hf);
    rr(OFS_INT_ST);
    chk("status", rd, 32'h0);
    wr(OFS_CTRL, 32'h81);
    rr(OFS_CTRL);
    chk("rd off", rd[0], 1'b0);
    rr(OFS_INT_ST);
    chk("no read", rd[1], 1'b0);
    // enable first: a start only counts once the enable bit already stands
    wr(OFS_CTRL, 32'h82);
    for (i = 0; i < 32; i++) begin
      wr(OFS_ADDR_LO, {p[2:0], 5'(i)});
      wr(OFS_CTRL, 32'h83);
      poll(CTRL_RD_START, OFS_CTRL);
      rr(OFS_RD_DATA);
      chk("word", rd[15:0], mdl[i][15:0]);
    end
    wr(OFS_INT_EN, 32'hf);
    repeat (2) @(posedge CLOCK);
    chk("irq", IRQ, 1'b1);
    end_sim;
  end
endmodule
